/* bcf_chopper_ctrl.sv */
// Braking chopper control, fault latching, indicators and AXI4-Lite status access.
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module bcf_chopper_ctrl #(
  parameter int DEBOUNCE_CYC = bcf_pkg::DEBOUNCE_CYC,
  parameter int FLASH_ON_CYC = bcf_pkg::FLASH_ON_CYC,
  parameter int FLASH_GAP_CYC = bcf_pkg::FLASH_GAP_CYC,
  parameter int FLASH_PAUSE_CYC = bcf_pkg::FLASH_PAUSE_CYC,
  parameter int DB_W = 20,
  parameter int TIMER_W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  // Dry contacts, high when closed.
  input wire logic enable_in,
  input wire logic fault_reset_in,
  input wire logic master_select_in,
  input wire logic discharge_in,
  // Comparator and sensor inputs, high when asserted.
  input wire logic bus_over_setpoint,
  input wire logic bus_below_lower,
  input wire logic bus_present,
  input wire logic logic_power_present,
  input wire logic fuse_in_ok,
  input wire logic fuse_out_ok,
  input wire logic overtemp,
  input wire logic instantaneous_overcurrent,
  input wire logic switch_shorted,
  // Shared control-signal port.
  input wire logic ctrl_sig_i,
  output logic ctrl_sig_o,
  output logic ctrl_sig_oe_n,
  // Power and indicator outputs, high when lit or closed.
  output logic braking_switch,
  output logic led_bus,
  output logic led_power,
  output logic led_braking,
  output logic control_ready,
  output logic power_stage_ready,
  output logic mode_master,
  output logic no_overcurrent,
  output logic logic_power_ok,
  output logic temp_ok,
  output logic not_shorted,
  // AXI4-Lite slave.
  input wire logic [bcf_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [bcf_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int NC = bcf_pkg::N_CONTACTS;
  localparam int NF = bcf_pkg::N_FAULTS;
  localparam logic [DB_W-1:0] DB_LAST = DB_W'(DEBOUNCE_CYC - 1);
  localparam logic [TIMER_W-1:0] ON_LAST = TIMER_W'(FLASH_ON_CYC - 1);
  localparam logic [TIMER_W-1:0] GAP_LAST = TIMER_W'(FLASH_GAP_CYC - 1);
  localparam logic [TIMER_W-1:0] PAUSE_LAST = TIMER_W'(FLASH_PAUSE_CYC - 1);
  localparam logic [7:0] MM_LAST = 8'(bcf_pkg::MISMATCH_CYC - 1);
  localparam logic [1:0] RESETS_TO_SHOW_M1 = bcf_pkg::RESETS_TO_SHOW - 2'h1;

  // ****************************************************************************
  // Contact filtering
  // ****************************************************************************
  logic [NC-1:0] contact_raw;
  logic [NC-1:0] db_level;
  logic [NC-1:0] db_rise;

  assign contact_raw[bcf_pkg::IN_ENABLE] = enable_in;
  assign contact_raw[bcf_pkg::IN_RESET] = fault_reset_in;
  assign contact_raw[bcf_pkg::IN_MASTER] = master_select_in;
  assign contact_raw[bcf_pkg::IN_DISCHARGE] = discharge_in;

  bcf_db_if db_if [NC] ();

  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : g_contact
      assign db_if[g].raw = contact_raw[g];
      assign db_level[g] = db_if[g].level;
      assign db_rise[g] = db_if[g].rise;
      bcf_debounce #(
        .CNT_W(DB_W),
        .STABLE_LAST(DB_LAST)
      ) u_debounce (
        .aclk(aclk),
        .aresetn(aresetn),
        .port(db_if[g])
      );
    end
  endgenerate

  // ****************************************************************************
  // State
  // ****************************************************************************
  typedef struct packed {
    logic demand;
    logic sw_on;
    logic discharging;
    logic [NF-1:0] faults;
    logic [2:0] last_code;
    logic [1:0] reset_count;
    logic display;
    bcf_pkg::bcf_flash_e fl_state;
    logic [TIMER_W-1:0] fl_timer;
    logic [2:0] fl_count;
    logic [7:0] mm_count;
    logic led_power;
    logic led_bus;
    logic led_braking;
    logic ctrl_ready;
    logic pwr_ready;
    logic master;
    logic no_ioc;
    logic logic_ok;
    logic temp_ok;
    logic not_short;
    logic sig_o;
    logic sig_oe_n;
    logic inhibit;
    logic sw_reset;
    logic aw_got;
    logic w_got;
    logic [bcf_pkg::ADDR_W-1:0] awaddr;
    logic [1:0] wbits;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } bcf_state_s;

  bcf_state_s s_r;
  bcf_state_s s_nxt;

  logic enabled;
  logic reset_pulse;
  logic logic_good;
  logic [NF-1:0] cause;
  logic [NF-1:0] clear_mask;
  logic [NF-1:0] new_fault;
  logic [2:0] shown_code;
  logic master_cmd;
  logic discharge_req;
  logic ctrl_fault;

  assign s_axi_awready = ~s_r.aw_got & ~s_r.bvalid;
  assign s_axi_wready = ~s_r.w_got & ~s_r.bvalid;
  assign s_axi_arready = ~s_r.rvalid;

  always_comb begin
    s_nxt = s_r;
    s_nxt.sw_reset = 1'b0;

    // ****************************************************************************
    // Mode, enable and fault latches
    // ****************************************************************************
    s_nxt.master = db_level[bcf_pkg::IN_MASTER];
    enabled = db_level[bcf_pkg::IN_ENABLE] & ~s_r.inhibit;
    reset_pulse = db_rise[bcf_pkg::IN_RESET] | s_r.sw_reset;
    logic_good = logic_power_present & fuse_in_ok & fuse_out_ok;

    // Another master drives the shared line against us for a filtered time.
    if (s_r.master && !s_r.sig_oe_n && ctrl_sig_i != s_r.sig_o) begin
      if (s_r.mm_count != MM_LAST) begin
        s_nxt.mm_count = s_r.mm_count + 1'b1;
      end
    end else begin
      s_nxt.mm_count = '0;
    end

    cause = '0;
    cause[bcf_pkg::F_LOGIC] = ~logic_good;
    cause[bcf_pkg::F_TEMP] = overtemp;
    cause[bcf_pkg::F_SHORT] = switch_shorted;
    cause[bcf_pkg::F_IOC] = instantaneous_overcurrent;
    cause[bcf_pkg::F_MISMATCH] = (s_r.mm_count == MM_LAST);

    // A cause present in the clearing cycle sets again, so set wins over clear.
    clear_mask = reset_pulse ? (~cause & ~bcf_pkg::POWER_ONLY_FAULTS)
                 : '0;
    s_nxt.faults = (s_r.faults & ~clear_mask) | cause;

    new_fault = cause & ~s_r.faults;
    for (int i = 0; i < NF; i++) begin
      if (new_fault[i]) begin
        s_nxt.last_code = 3'(i + 1);
      end
    end

    ctrl_fault = s_r.faults[bcf_pkg::F_LOGIC] | s_r.faults[bcf_pkg::F_MISMATCH];
    s_nxt.ctrl_ready = enabled & ~ctrl_fault;
    s_nxt.pwr_ready = logic_good & ~s_r.faults[bcf_pkg::F_IOC]
                      & ~s_r.faults[bcf_pkg::F_SHORT] & ~overtemp;

    // ****************************************************************************
    // Regulation and the shared control port
    // ****************************************************************************
    if (!enabled) begin
      s_nxt.demand = 1'b0;
    end else if (bus_over_setpoint) begin
      s_nxt.demand = 1'b1;
    end else if (bus_below_lower) begin
      s_nxt.demand = 1'b0;
    end

    discharge_req = db_level[bcf_pkg::IN_DISCHARGE] & enabled & s_r.master;
    s_nxt.discharging = discharge_req;
    master_cmd = s_r.demand | discharge_req;

    if (s_r.master) begin
      s_nxt.sig_oe_n = 1'b0;
      s_nxt.sig_o = s_r.ctrl_ready & master_cmd;
      s_nxt.sw_on = s_r.ctrl_ready & master_cmd & s_r.pwr_ready;
    end else begin
      s_nxt.sig_oe_n = 1'b1;
      s_nxt.sig_o = 1'b0;
      s_nxt.sw_on = ctrl_sig_i & s_r.ctrl_ready & s_r.pwr_ready;
    end

    s_nxt.led_bus = bus_present;
    s_nxt.led_braking = s_nxt.sw_on | discharge_req;
    s_nxt.no_ioc = ~s_nxt.faults[bcf_pkg::F_IOC];
    s_nxt.logic_ok = logic_good;
    s_nxt.temp_ok = ~overtemp;
    s_nxt.not_short = ~s_nxt.faults[bcf_pkg::F_SHORT];

    // ****************************************************************************
    // Last-fault readout and flash sequencer
    // ****************************************************************************
    if (enabled) begin
      s_nxt.display = 1'b0;
      s_nxt.reset_count = '0;
    end else if (db_rise[bcf_pkg::IN_RESET] && !s_r.display) begin
      if (s_r.reset_count == RESETS_TO_SHOW_M1) begin
        s_nxt.display = 1'b1;
        s_nxt.reset_count = '0;
      end else begin
        s_nxt.reset_count = s_r.reset_count + 1'b1;
      end
    end

    shown_code = bcf_pkg::CODE_NONE;
    if (s_r.display) begin
      shown_code = s_r.last_code;
    end else begin
      for (int i = NF - 1; i >= 0; i--) begin
        if (s_r.faults[i]) begin
          shown_code = 3'(i + 1);
        end
      end
    end

    s_nxt.fl_timer = s_r.fl_timer + 1'b1;
    case (s_r.fl_state)
      bcf_pkg::FL_IDLE: begin
        s_nxt.fl_timer = '0;
        s_nxt.fl_count = 3'h1;
        if (shown_code != bcf_pkg::CODE_NONE) begin
          s_nxt.fl_state = bcf_pkg::FL_ON;
        end
      end
      bcf_pkg::FL_ON: begin
        if (s_r.fl_timer == ON_LAST) begin
          s_nxt.fl_timer = '0;
          s_nxt.fl_state = (s_r.fl_count >= shown_code) ? bcf_pkg::FL_PAUSE : bcf_pkg::FL_GAP;
        end
      end
      bcf_pkg::FL_GAP: begin
        if (s_r.fl_timer == GAP_LAST) begin
          s_nxt.fl_timer = '0;
          s_nxt.fl_count = s_r.fl_count + 1'b1;
          s_nxt.fl_state = bcf_pkg::FL_ON;
        end
      end
      bcf_pkg::FL_PAUSE: begin
        if (s_r.fl_timer == PAUSE_LAST) begin
          s_nxt.fl_timer = '0;
          s_nxt.fl_count = 3'h1;
          s_nxt.fl_state = bcf_pkg::FL_ON;
        end
      end
      default: begin
        s_nxt.fl_state = bcf_pkg::FL_IDLE;
      end
    endcase
    if (shown_code == bcf_pkg::CODE_NONE) begin
      s_nxt.fl_state = bcf_pkg::FL_IDLE;
    end
    s_nxt.led_power = (s_nxt.fl_state == bcf_pkg::FL_IDLE)
                      | (s_nxt.fl_state == bcf_pkg::FL_ON);

    // ****************************************************************************
    // AXI4-Lite write channel
    // ****************************************************************************
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wbits = s_axi_wdata[1:0];
      s_nxt.wstrb0 = s_axi_wstrb[0];
    end
    if (s_nxt.aw_got && s_nxt.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = bcf_pkg::RESP_OKAY;
      case (s_nxt.awaddr)
        bcf_pkg::REG_CTRL: begin
          if (s_nxt.wstrb0) begin
            s_nxt.sw_reset = s_nxt.wbits[bcf_pkg::CTRL_SW_RESET];
            s_nxt.inhibit = s_nxt.wbits[bcf_pkg::CTRL_INHIBIT];
          end
        end
        bcf_pkg::REG_STATUS, bcf_pkg::REG_LAST_FAULT: begin
          s_nxt.bresp = bcf_pkg::RESP_OKAY;
        end
        default: begin
          s_nxt.bresp = bcf_pkg::RESP_SLVERR;
        end
      endcase
    end

    // ****************************************************************************
    // AXI4-Lite read channel
    // ****************************************************************************
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = bcf_pkg::RESP_OKAY;
      s_nxt.rdata = '0;
      case (s_axi_araddr)
        bcf_pkg::REG_STATUS: begin
          s_nxt.rdata[bcf_pkg::ST_FAULTS +: NF] = s_r.faults;
          s_nxt.rdata[bcf_pkg::ST_MASTER] = s_r.master;
          s_nxt.rdata[bcf_pkg::ST_SWITCH] = s_r.sw_on;
          s_nxt.rdata[bcf_pkg::ST_CTRL_READY] = s_r.ctrl_ready;
          s_nxt.rdata[bcf_pkg::ST_PWR_READY] = s_r.pwr_ready;
          s_nxt.rdata[bcf_pkg::ST_DISPLAY] = s_r.display;
          s_nxt.rdata[bcf_pkg::ST_DISCHARGE] = s_r.discharging;
        end
        bcf_pkg::REG_LAST_FAULT: begin
          s_nxt.rdata[2:0] = s_r.last_code;
        end
        bcf_pkg::REG_CTRL: begin
          s_nxt.rdata[bcf_pkg::CTRL_INHIBIT] = s_r.inhibit;
        end
        default: begin
          s_nxt.rresp = bcf_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // The control port must not drive the shared line out of reset, so its enable starts high.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.sig_oe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************************
  // Outputs
  // ****************************************************************************
  assign braking_switch = s_r.sw_on;
  assign ctrl_sig_o = s_r.sig_o;
  assign ctrl_sig_oe_n = s_r.sig_oe_n;
  assign led_bus = s_r.led_bus;
  assign led_power = s_r.led_power;
  assign led_braking = s_r.led_braking;
  assign control_ready = s_r.ctrl_ready;
  assign power_stage_ready = s_r.pwr_ready;
  assign mode_master = s_r.master;
  assign no_overcurrent = s_r.no_ioc;
  assign logic_power_ok = s_r.logic_ok;
  assign temp_ok = s_r.temp_ok;
  assign not_shorted = s_r.not_short;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rvalid = s_r.rvalid;

endmodule : bcf_chopper_ctrl

/* bcf_chopper_ctrl_chk.sv */
// Port checker for the braking chopper controller.
`timescale 1ns/1ps
// ****************************************************************************
// Checker
// ****************************************************************************
module bcf_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bus_present,
  input wire logic logic_power_present,
  input wire logic fuse_in_ok,
  input wire logic fuse_out_ok,
  input wire logic overtemp,
  input wire logic instantaneous_overcurrent,
  input wire logic braking_switch,
  input wire logic led_bus,
  input wire logic led_braking,
  input wire logic control_ready,
  input wire logic power_stage_ready,
  input wire logic mode_master,
  input wire logic no_overcurrent,
  input wire logic logic_power_ok,
  input wire logic temp_ok,
  input wire logic ctrl_sig_oe_n
);
  logic [1:0] up_r;
  logic lp;
  assign lp = logic_power_present & fuse_in_ok & fuse_out_ok;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // The bus-lamp and logic-power checks wait three edges after reset so that reset values are not compared.
  always_ff @(posedge aclk) begin
    if (!aresetn) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  chk_bus_led: assert property (up_r == 2'h3 && $past(bus_present) == bus_present
    && $past(bus_present, 2) == bus_present |-> led_bus == bus_present)
    else $error("bus indicator wrong");
  chk_logic_pwr: assert property (up_r == 2'h3 && $past(lp) == lp && $past(lp, 2) == lp
    |-> logic_power_ok == lp) else $error("logic power ok wrong");
  chk_ioc_open: assert property ($rose(instantaneous_overcurrent) |-> ##[1:3]
    (!no_overcurrent && !power_stage_ready)) else $error("overcurrent not latched");
  chk_ioc_hold: assert property ($fell(no_overcurrent) |=> !no_overcurrent [*5])
    else $error("overcurrent latch released early");
  chk_temp_stop: assert property (overtemp [*4] |-> !temp_ok && !power_stage_ready
    && !braking_switch) else $error("overtemp does not stop braking");
  chk_brk_led: assert property (braking_switch |-> ##[0:2] led_braking)
    else $error("braking indicator dark");
  chk_mode_drive: assert property ($rose(mode_master) |-> ##[0:2] !ctrl_sig_oe_n)
    else $error("master does not drive control line");
  chk_idle_sw: assert property (!control_ready && !$past(control_ready)
    && !$past(control_ready, 2) |-> !braking_switch) else $error("switching without ready");
  cover property ($fell(no_overcurrent));
  cover property (braking_switch && mode_master);
  cover property (braking_switch && !mode_master);
endmodule : bcf_chk
bind bcf_chopper_ctrl bcf_chk bcf_chk_i (.*);

/* bcf_db_if.sv */
// Carrier between a dry-contact filter and its user.
`timescale 1ns/1ps
interface bcf_db_if;
  logic raw;
  logic level;
  logic rise;

  modport dev (
    input raw,
    output level,
    output rise
  );

  modport user (
    output raw,
    input level,
    input rise
  );
endinterface : bcf_db_if

/* bcf_debounce.sv */
// Synchroniser and stable-count filter for one dry contact.
`timescale 1ns/1ps
module bcf_debounce #(
  parameter int CNT_W = 20,
  parameter logic [CNT_W-1:0] STABLE_LAST = 20'hF_423F
) (
  input wire logic aclk,
  input wire logic aresetn,
  bcf_db_if.dev port
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic level;
    logic rise;
    logic [CNT_W-1:0] cnt;
  } bcf_db_s;

  bcf_db_s s_r;
  bcf_db_s s_nxt;

  // Only sync2 reads sync1; the filter looks at sync2 alone.
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync1 = port.raw;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.rise = 1'b0;
    if (s_r.sync2 == s_r.level) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt == STABLE_LAST) begin
      s_nxt.level = s_r.sync2;
      s_nxt.rise = s_r.sync2;
      s_nxt.cnt = '0;
    end else begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign port.level = s_r.level;
  assign port.rise = s_r.rise;

endmodule : bcf_debounce

/* bcf_peer_model.sv */
// Peer braking module on the shared control line.
`timescale 1ns/1ps
module bcf_peer_model (
  input wire logic aclk,
  input wire logic dut_o,
  input wire logic dut_oe_n,
  input wire logic peer_drive,
  input wire logic peer_val,
  output logic line
);
  // A released line shows the inverse of its last level, never a stale value.
  logic last_r = 1'h0;
  always_ff @(posedge aclk) last_r <= line;
  always_comb begin
    if (!dut_oe_n && peer_drive) line = !dut_o;
    else if (!dut_oe_n) line = dut_o;
    else if (peer_drive) line = peer_val;
    else line = !last_r;
  end
endmodule : bcf_peer_model

/* bcf_pkg.sv */
// Constants, types and register map of the braking chopper fault and status controller.
// ****************************************************************************
// ****************************************************************************
package bcf_pkg;

  localparam int CLK_HZ = 100_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;

  // ****************************************************************************
  // Timing
  // ****************************************************************************
  localparam int DEBOUNCE_MS = 10;
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
  localparam int FLASH_ON_MS = 250;
  localparam int FLASH_ON_CYC = FLASH_ON_MS * CYC_PER_MS;
  localparam int FLASH_GAP_MS = 250;
  localparam int FLASH_GAP_CYC = FLASH_GAP_MS * CYC_PER_MS;
  localparam int FLASH_PAUSE_MS = 1500;
  localparam int FLASH_PAUSE_CYC = FLASH_PAUSE_MS * CYC_PER_MS;
  localparam int MISMATCH_US = 1;
  localparam int MISMATCH_CYC = MISMATCH_US * CYC_PER_US;

  // ****************************************************************************
  // Contact inputs and fault bits
  // ****************************************************************************
  localparam int N_CONTACTS = 4;
  localparam int IN_ENABLE = 0;
  localparam int IN_RESET = 1;
  localparam int IN_MASTER = 2;
  localparam int IN_DISCHARGE = 3;

  localparam int N_FAULTS = 5;
  localparam int F_LOGIC = 0;
  localparam int F_TEMP = 1;
  localparam int F_SHORT = 2;
  localparam int F_IOC = 3;
  localparam int F_MISMATCH = 4;
  // Faults that only a power cycle removes.
  localparam logic [N_FAULTS-1:0] POWER_ONLY_FAULTS = 5'h14;

  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [1:0] RESETS_TO_SHOW = 2'h3;

  typedef enum logic [1:0] {
    FL_IDLE  = 2'b00,
    FL_ON    = 2'b01,
    FL_GAP   = 2'b10,
    FL_PAUSE = 2'b11
  } bcf_flash_e;

  // ****************************************************************************
  // Register map
  // ****************************************************************************
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_LAST_FAULT = 4'h4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h8;

  localparam int ST_FAULTS = 0;
  localparam int ST_MASTER = 5;
  localparam int ST_SWITCH = 6;
  localparam int ST_CTRL_READY = 7;
  localparam int ST_PWR_READY = 8;
  localparam int ST_DISPLAY = 9;
  localparam int ST_DISCHARGE = 10;

  localparam int CTRL_SW_RESET = 0;
  localparam int CTRL_INHIBIT = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : bcf_pkg

/* tb_braking_chopper_fault_status_control.sv */
// Self-checking testbench of the braking chopper controller.
`timescale 1ns/1ps
module tb_braking_chopper_fault_status_control;
  logic aclk = 1'h0, aresetn = 1'h0, enable_in = 1'h0, fault_reset_in = 1'h0;
  logic master_select_in = 1'h0, discharge_in = 1'h0, bus_over_setpoint = 1'h0;
  logic bus_below_lower = 1'h0, bus_present = 1'h0, logic_power_present = 1'h1;
  logic fuse_in_ok = 1'h1, fuse_out_ok = 1'h1, overtemp = 1'h0, switch_shorted = 1'h0;
  logic instantaneous_overcurrent = 1'h0, peer_drive = 1'h0, peer_val = 1'h0;
  logic ctrl_sig_i, ctrl_sig_o, ctrl_sig_oe_n, braking_switch, led_bus, led_power, led_braking;
  logic control_ready, power_stage_ready, mode_master, no_overcurrent, logic_power_ok;
  logic temp_ok, not_shorted, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_rvalid;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0, v;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int seed, error_cnt = 0, check_count = 0, n, k;
  always #5 aclk = ~aclk;
  bcf_chopper_ctrl #(.DEBOUNCE_CYC(4), .FLASH_ON_CYC(5), .FLASH_GAP_CYC(5),
    .FLASH_PAUSE_CYC(20)) bcf_chopper_ctrl_i (.*);
  bcf_peer_model bcf_peer_model_i (.aclk(aclk), .dut_o(ctrl_sig_o), .dut_oe_n(ctrl_sig_oe_n),
    .peer_drive(peer_drive), .peer_val(peer_val), .line(ctrl_sig_i));
  // ****************************************************************************
  // Helpers
  // ****************************************************************************
  function logic exp_lp(logic [3:0] x);
    return x[0] & x[1] & x[2];
  endfunction : exp_lp
  task complete_run;
    $display("Checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task chk(string nm, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
    $display("Test %s done", nm);
  endtask : chk
  task cyc(int c);
    repeat (c) @(posedge aclk);
  endtask : cyc
  // Handshakes are sampled at the falling edge, where they equal their value at the next rise.
  task axi(logic wr, logic [3:0] a, logic [31:0] d);
    int i;
    logic aw, w, ar, b;
    @(posedge aclk);
    if (wr) {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
    if (wr) {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    else {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    for (i = 0; i < 40; i++) begin
      @(negedge aclk);
      {aw, w, ar} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready,
        s_axi_arvalid & s_axi_arready};
      b = wr ? s_axi_bvalid : s_axi_rvalid;
      {q, r} = {s_axi_rdata, wr ? s_axi_bresp : s_axi_rresp};
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
      if (ar) s_axi_arvalid <= 1'h0;
      if (b) {s_axi_bready, s_axi_rready} <= 2'h0;
      if (b) break;
    end
    if (i == 40) begin
      error_cnt++;
      complete_run;
    end
  endtask : axi
  task tgl;
    @(posedge aclk) fault_reset_in <= 1'h1;
    cyc(10);
    @(posedge aclk) fault_reset_in <= 1'h0;
    cyc(10);
  endtask : tgl
  // Counts the flashes of one group, from the end of one long pause to the next.
  task flashes;
    int i, lo;
    logic p, st;
    {n, lo, p, st} = 0;
    for (i = 0; i < 300; i++) begin
      @(negedge aclk);
      if (led_power && !p && lo > 8 && st) break;
      if (led_power && !p && lo > 8) st = 1'h1;
      if (led_power && !p && st) n++;
      lo = led_power ? 0 : lo + 1;
      p = led_power;
    end
    if (i == 300) begin
      error_cnt++;
      complete_run;
    end
  endtask : flashes
  // ****************************************************************************
  // Scenarios
  // ****************************************************************************
  initial begin
    seed = 16;
    cyc(10);
    aresetn <= 1'h1;
    axi(1'h0, 4'hc, 32'h0);
    chk("read unmapped", r, bcf_pkg::RESP_SLVERR);
    axi(1'h1, 4'hc, 32'h1);
    chk("write unmapped", r, bcf_pkg::RESP_SLVERR);
    {master_select_in, enable_in, bus_present} <= 3'h7;
    cyc(14);
    chk("master", {mode_master, ctrl_sig_oe_n}, 2'h2);
    chk("ready", {control_ready, led_power}, 2'h3);
    for (k = 0; k < 2; k++) begin
      @(posedge aclk) {bus_over_setpoint, bus_below_lower} <= k ? 2'h1 : 2'h2;
      @(posedge aclk) {bus_over_setpoint, bus_below_lower} <= 2'h0;
      cyc(4);
      chk("hyst", {braking_switch, ctrl_sig_o, led_braking}, k ? 3'h0 : 3'h7);
    end
    @(posedge aclk) discharge_in <= 1'h1;
    cyc(12);
    chk("discharge", {braking_switch, led_braking}, 2'h3);
    @(posedge aclk) enable_in <= 1'h0;
    cyc(12);
    chk("disabled", {braking_switch, control_ready}, 2'h0);
    {discharge_in, enable_in} <= 2'h1;
    cyc(12);
    instantaneous_overcurrent <= 1'h1;
    @(posedge aclk) instantaneous_overcurrent <= 1'h0;
    cyc(4);
    chk("ioc open", {no_overcurrent, power_stage_ready}, 2'h0);
    @(posedge aclk) bus_over_setpoint <= 1'h1;
    cyc(4);
    chk("drive slaves", {ctrl_sig_o, braking_switch}, 2'h2);
    @(posedge aclk) {bus_over_setpoint, bus_below_lower} <= 2'h1;
    @(posedge aclk) bus_below_lower <= 1'h0;
    axi(1'h0, bcf_pkg::REG_LAST_FAULT, 32'h0);
    chk("last code", q, 32'h4);
    flashes;
    chk("ioc flashes", n, 4);
    @(posedge aclk) enable_in <= 1'h0;
    repeat (3) tgl;
    chk("ioc cleared", no_overcurrent, 1'h1);
    flashes;
    chk("readout", n, 4);
    @(posedge aclk) {enable_in, overtemp} <= 2'h3;
    cyc(12);
    chk("overtemp", {temp_ok, power_stage_ready}, 2'h0);
    tgl;
    @(posedge aclk) overtemp <= 1'h0;
    cyc(4);
    axi(1'h0, bcf_pkg::REG_STATUS, 32'h0);
    chk("temp kept", {temp_ok, q[1]}, 2'h3);
    axi(1'h1, bcf_pkg::REG_CTRL, 32'h3);
    cyc(2);
    chk("inhibit", control_ready, 1'h0);
    axi(1'h0, bcf_pkg::REG_CTRL, 32'h0);
    chk("ctrl read", q, 32'h2);
    axi(1'h0, bcf_pkg::REG_STATUS, 32'h0);
    chk("sw reset", q[1], 1'h0);
    axi(1'h1, bcf_pkg::REG_CTRL, 32'h0);
    {master_select_in, peer_drive, peer_val} <= 3'h3;
    cyc(14);
    chk("slave", {mode_master, ctrl_sig_oe_n, braking_switch}, 3'h3);
    {master_select_in, switch_shorted} <= 2'h3;
    @(posedge aclk) switch_shorted <= 1'h0;
    cyc(130);
    tgl;
    axi(1'h0, bcf_pkg::REG_STATUS, 32'h0);
    chk("mm", {q[4], q[2], not_shorted, control_ready}, 4'hc);
    for (k = 0; k < 20; k++) begin
      v = $random(seed);
      {bus_present, logic_power_present, fuse_in_ok, fuse_out_ok} <= v;
      cyc(4);
      chk("bus lamp", led_bus, v[3]);
      chk("logic ok", logic_power_ok, exp_lp(v));
    end
    complete_run;
  end
endmodule : tb_braking_chopper_fault_status_control
